// ### hw/isnbm_array.sv
// Byte array with one synchronous write port and one direct read port.
// Assumes the write enable comes from logic on the same clock.
`timescale 1ns/1ps
`default_nettype none

module isnbm_array #(
  parameter int ADDR_W = 9,
  parameter int DATA_W = 8
) (
  input  wire logic              clk_i,
  input  wire logic              we_i,
  input  wire logic [ADDR_W-1:0] waddr_i,
  input  wire logic [DATA_W-1:0] wdata_i,
  input  wire logic [ADDR_W-1:0] raddr_i,
  output var  logic [DATA_W-1:0] rdata_o
);

  // Contents model nonvolatile cells, so reset leaves them alone.
  logic [DATA_W-1:0] mem [2**ADDR_W];

  always_ff @(posedge clk_i) begin
    if (we_i) begin
      mem[waddr_i] <= wdata_i;
    end
  end

  assign rdata_o = mem[raddr_i];

endmodule : isnbm_array

`default_nettype wire

// ### hw/isnbm_sync.sv
// Two-flop synchroniser for a group of independent levels.
// Assumes each bit is a level that holds for several destination clocks.
`timescale 1ns/1ps
`default_nettype none

module isnbm_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk_i,
  input  wire logic             resetn_i,
  input  wire logic [WIDTH-1:0] d_i,
  output var  logic [WIDTH-1:0] q_o
);

  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
  } isnbm_sync_s;

  isnbm_sync_s r_q;
  isnbm_sync_s r_d;

  // The first stage feeds only the second stage.
  always_comb begin
    r_d    = r_q;
    r_d.s1 = d_i;
    r_d.s2 = r_q.s1;
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      r_q <= '0;
    end else begin
      r_q <= r_d;
    end
  end

  assign q_o = r_q.s2;

endmodule : isnbm_sync

`default_nettype wire

// ### hw/isnbm_top.sv
// Two-wire serial slave front end with a 512-byte array and APB status.
// Assumes link_clk_i oversamples the serial pins and that resetn_i is
// the power-on reset of the part.
`timescale 1ns/1ps
`default_nettype none

module isnbm_top
  import isnbm_pkg::*;
#(
  // Device type code; this default value is arbitrary.
  parameter logic [3:0] DEV_TYPE = 4'h6
) (
  input  wire logic        sys_clk_i,
  input  wire logic        resetn_i,
  input  wire logic        link_clk_i,
  input  wire logic [11:0] paddr_i,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [31:0] pwdata_i,
  input  wire logic [3:0]  pstrb_i,
  output var  logic [31:0] prdata_o,
  output var  logic        pready_o,
  output var  logic        pslverr_o,
  input  wire logic        scl_i,
  input  wire logic        sda_i,
  output var  logic        sda_o,
  output var  logic        sda_oe_o,
  input  wire logic        wp_i,
  input  wire logic [1:0]  device_select_pins_i
);

  import isnbm_pkg::*;

  // ****************************************************************
  // State of both clock domains
  // ****************************************************************
  typedef struct packed {
    isnbm_state_e                    st;
    isnbm_kind_e                     kind;
    logic [3:0]                      bitcnt;
    logic [DATA_W-1:0]               shreg;
    logic                            rw;
    logic [isnbm_pkg::ADDR_W-1:0]    addr;
    logic                            scl_p;
    logic                            sda_p;
    logic                            sda_oe;
    logic                            commit_tog;
  } isnbm_link_s;

  typedef struct packed {
    logic        ctrl_en;
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
    logic [15:0] wcount;
    logic        tog_p;
  } isnbm_sys_s;

  isnbm_link_s ln_q;
  isnbm_link_s ln_d;
  isnbm_sys_s  sy_q;
  isnbm_sys_s  sy_d;

  // ****************************************************************
  // Crossings
  // ****************************************************************
  logic [5:0]        pin_s;
  logic [2:0]        back_s;
  logic              scl_s;
  logic              sda_s;
  logic              wp_s;
  logic [1:0]        sel_s;
  logic              en_s;
  logic              mem_we;
  logic [DATA_W-1:0] mem_rdata;

  // Pins and the enable level enter the link domain through two flops.
  isnbm_sync #(
    .WIDTH (6)
  ) u_pin_sync (
    .clk_i    (link_clk_i),
    .resetn_i (resetn_i),
    .d_i      ({sy_q.ctrl_en, device_select_pins_i, wp_i, sda_i, scl_i}),
    .q_o      (pin_s)
  );

  // Reset clears these flops, so select and protect read low until the pin samples have passed both flops, two link clocks after reset.
  assign scl_s = pin_s[0];
  assign sda_s = pin_s[1];
  assign wp_s  = pin_s[2]; // see [R9]
  assign sel_s = pin_s[4:3]; // see [R6]
  assign en_s  = pin_s[5];

  // Commit events cross as a toggle; status bits cross as levels.
  isnbm_sync #(
    .WIDTH (3)
  ) u_back_sync (
    .clk_i    (sys_clk_i),
    .resetn_i (resetn_i),
    .d_i      ({wp_s, (ln_q.st != ST_IDLE), ln_q.commit_tog}),
    .q_o      (back_s)
  );

  isnbm_array #(
    .ADDR_W (isnbm_pkg::ADDR_W),
    .DATA_W (DATA_W)
  ) u_array (
    .clk_i   (link_clk_i),
    .we_i    (mem_we),
    .waddr_i (ln_q.addr),
    .wdata_i (ln_q.shreg),
    .raddr_i (ln_q.addr),
    .rdata_o (mem_rdata)
  );

  // ****************************************************************
  // Serial engine
  // ****************************************************************
  logic scl_rise;
  logic scl_fall;
  logic start_cond;
  logic stop_cond;
  logic byte_done;
  logic addr_hit;

  assign scl_rise   = scl_s & ~ln_q.scl_p;
  assign scl_fall   = ~scl_s & ln_q.scl_p;
  assign start_cond = scl_s & ln_q.scl_p & ln_q.sda_p & ~sda_s;
  assign stop_cond  = scl_s & ln_q.scl_p & ~ln_q.sda_p & sda_s;
  assign byte_done  = scl_fall & (ln_q.bitcnt == BITS_PER_BYTE);
  assign addr_hit   =
    (ln_q.shreg[SA_TYPE_MSB:SA_TYPE_LSB] == DEV_TYPE) &
    (ln_q.shreg[SA_SEL_MSB:SA_SEL_LSB] == sel_s) & en_s; // see [R5] [R13]

  always_comb begin
    ln_d       = ln_q;
    mem_we     = 1'b0;
    ln_d.scl_p = scl_s;
    ln_d.sda_p = sda_s;
    if (start_cond) begin
      // A START aborts any byte in flight, so nothing half-received commits.
      ln_d.st     = ST_RX; // see [R16]
      ln_d.kind   = K_DEV;
      ln_d.bitcnt = 4'h0;
      ln_d.sda_oe = 1'b0;
    end else if (stop_cond) begin
      ln_d.st     = ST_IDLE; // see [R16]
      ln_d.sda_oe = 1'b0;
    end else begin
      case (ln_q.st)
        ST_IDLE: begin
          ln_d.sda_oe = 1'b0;
        end
        ST_RX: begin
          if (scl_rise) begin
            // Bits arrive msb first, one per rising clock.
            ln_d.shreg  = {ln_q.shreg[DATA_W-2:0], sda_s}; // see [R7] [R10]
            ln_d.bitcnt = ln_q.bitcnt + 4'h1;
          end else if (byte_done) begin
            case (ln_q.kind)
              K_DEV: begin
                if (addr_hit) begin
                  ln_d.addr[isnbm_pkg::ADDR_W-1] =
                    ln_q.shreg[SA_PAGE_BIT]; // see [R1] [R15]
                  ln_d.rw     = ln_q.shreg[SA_RW_BIT]; // see [R13]
                  ln_d.kind   = K_WORD;
                  ln_d.st     = ST_ACK;
                  ln_d.sda_oe = 1'b1; // see [R8]
                end else begin
                  ln_d.st = ST_IDLE;
                end
              end
              K_WORD: begin
                ln_d.addr[WORD_W-1:0] = ln_q.shreg; // see [R2] [R1]
                ln_d.kind   = K_DATA;
                ln_d.st     = ST_ACK;
                ln_d.sda_oe = 1'b1;
              end
              K_DATA: begin
                // Commit right after the eighth bit, before the ack,
                // so the next transaction never waits on the array.
                mem_we = ~wp_s; // see [R3] [R4] [R9] [R16] [R18]
                ln_d.commit_tog = ln_q.commit_tog ^ ~wp_s;
                ln_d.addr   = ln_q.addr + 9'h001; // see [R14] [R18]
                ln_d.st     = ST_ACK;
                ln_d.sda_oe = 1'b1;
              end
              default: begin
                ln_d.st = ST_IDLE;
              end
            endcase
          end
        end
        ST_ACK: begin
          if (scl_fall) begin
            ln_d.bitcnt = 4'h0;
            if (ln_q.rw) begin
              // Reads carry no word address and go on from the latch.
              ln_d.shreg  = mem_rdata; // see [R15]
              ln_d.addr   = ln_q.addr + 9'h001; // see [R14]
              ln_d.sda_oe = ~mem_rdata[DATA_W-1]; // see [R7] [R8]
              ln_d.st     = ST_TX;
            end else begin
              ln_d.sda_oe = 1'b0;
              ln_d.st     = ST_RX;
            end
          end
        end
        ST_TX: begin
          if (scl_rise) begin
            ln_d.bitcnt = ln_q.bitcnt + 4'h1;
          end else if (scl_fall) begin
            if (ln_q.bitcnt == BITS_PER_BYTE) begin
              ln_d.sda_oe = 1'b0;
              ln_d.bitcnt = 4'h0;
              ln_d.st     = ST_TXACK;
            end else begin
              ln_d.shreg  = {ln_q.shreg[DATA_W-2:0], 1'b0}; // see [R10]
              ln_d.sda_oe = ~ln_q.shreg[DATA_W-2]; // see [R7] [R8]
            end
          end
        end
        ST_TXACK: begin
          if (scl_rise) begin
            ln_d.bitcnt = 4'h1;
            if (sda_s) begin
              ln_d.st = ST_IDLE; // see [R17]
            end
          end else if (scl_fall && ln_q.bitcnt != 4'h0) begin
            ln_d.bitcnt = 4'h0;
            ln_d.shreg  = mem_rdata;
            ln_d.addr   = ln_q.addr + 9'h001; // see [R14]
            ln_d.sda_oe = ~mem_rdata[DATA_W-1];
            ln_d.st     = ST_TX;
          end
        end
        default: begin
          ln_d.st     = ST_IDLE;
          ln_d.sda_oe = 1'b0;
        end
      endcase
    end
  end

  // The power-on reset is the only thing that initialises the engine.
  always_ff @(posedge link_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ln_q       <= '0; // see [R12]
      ln_q.st    <= ST_IDLE;
      ln_q.kind  <= K_DEV;
      ln_q.scl_p <= 1'b1;
      ln_q.sda_p <= 1'b1;
    end else begin
      ln_q <= ln_d; // see [R11]
    end
  end

  // Open drain: the data output is tied low and only its enable moves.
  assign sda_o    = 1'b0; // see [R8]
  assign sda_oe_o = ln_q.sda_oe;

  // ****************************************************************
  // APB slave
  // ****************************************************************
  logic apb_setup;
  logic apb_write;
  logic apb_bad;

  assign apb_setup = psel_i & ~penable_i;
  assign apb_write = psel_i & penable_i & sy_q.pready & pwrite_i;
  assign apb_bad   = (paddr_i != CTRL_OFF) & (pwrite_i |
                     ((paddr_i != STATUS_OFF) & (paddr_i != WCOUNT_OFF)));

  always_comb begin
    sy_d         = sy_q;
    sy_d.pready  = apb_setup;
    sy_d.tog_p   = back_s[0];
    if (back_s[0] != sy_q.tog_p) begin
      sy_d.wcount = sy_q.wcount + 16'h0001;
    end
    if (apb_setup) begin
      // Data and error are set up one cycle early so the answer is a flop.
      sy_d.pslverr = apb_bad;
      case (paddr_i)
        CTRL_OFF:   sy_d.prdata = {31'h0000_0000, sy_q.ctrl_en};
        STATUS_OFF: sy_d.prdata = {30'h0000_0000, back_s[2], back_s[1]};
        WCOUNT_OFF: sy_d.prdata = {16'h0000, sy_q.wcount};
        default:    sy_d.prdata = 32'h0000_0000;
      endcase
    end
    if (apb_write && !sy_q.pslverr && pstrb_i[0]) begin
      sy_d.ctrl_en = pwdata_i[CTRL_EN_BIT];
    end
  end

  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sy_q         <= '0;
      sy_q.ctrl_en <= CTRL_EN_RST;
      sy_q.wcount  <= WCOUNT_RST;
    end else begin
      sy_q <= sy_d;
    end
  end

  assign prdata_o  = sy_q.prdata;
  assign pready_o  = sy_q.pready;
  assign pslverr_o = sy_q.pslverr;

endmodule : isnbm_top

`default_nettype wire

// ### include/isnbm_pkg.sv
// Constants, field layouts and state types of the serial byte memory.
// Assumes a system clock for the register bus and a separate link clock
// that oversamples the two-wire serial pins.
//
// Summary of operation
// [R1] Page bit plus eight-bit word address form a nine-bit byte address.
// [R2] Word address is eight bits and picks one of 256 bytes.
// [R3] Each received data byte is stored at once, no write delay.
// [R4] A write completes before any following transaction can shift in.
// [R5] Respond only when select bits equal the strapped select pins.
// [R6] Unconnected select pins read as zero; the code has no pull-down, so after reset they read whatever the pin carries.
// [R7] Output bits change after clock falls; input bits sampled on rises.
// [R8] Data line is only pulled low or released, never driven high.
// [R9] Write-protect high blocks writes everywhere; low allows them.
// [R10] Each byte moves one bit at a time, both directions.
// [R11] Serial clock rates up to 1 MHz, including 100 and 400 kHz.
// [R12] Interface logic starts only from a simple power-on reset.
// [R13] Address byte: type, two select bits, page bit, direction bit.
// [R14] Address latch increments after each byte, wraps 1FFh to 000h.
// [R15] Writes send a word address; reads continue from the latch.
// [R16] A byte commits only after its eighth bit; START/STOP aborts.
// [R17] After a read byte is not acknowledged, release and idle.
// [R18] Protected writes are still acknowledged and advance the address.

package isnbm_pkg;

  // ****************************************************************
  // Array geometry
  // ****************************************************************
  localparam int ADDR_W    = 9;
  localparam int DATA_W    = 8;
  localparam int WORD_W    = 8;
  localparam int DEPTH     = 512;

  // ****************************************************************
  // Serial timing
  // ****************************************************************
  // The link clock must be at least eight times the serial clock.
  localparam int SCL_MAX_HZ   = 1_000_000;
  localparam int LINK_OVERSMP = 8;

  // ****************************************************************
  // Address byte fields
  // ****************************************************************
  localparam int SA_TYPE_MSB = 7;
  localparam int SA_TYPE_LSB = 4;
  localparam int SA_SEL_MSB  = 3;
  localparam int SA_SEL_LSB  = 2;
  localparam int SA_PAGE_BIT = 1;
  localparam int SA_RW_BIT   = 0;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [11:0] CTRL_OFF    = 12'h000;
  localparam logic [11:0] STATUS_OFF  = 12'h004;
  localparam logic [11:0] WCOUNT_OFF  = 12'h008;
  localparam int          CTRL_EN_BIT = 0;
  localparam logic        CTRL_EN_RST = 1'h1;
  localparam int          STAT_ACT_BIT = 0;
  localparam int          STAT_WP_BIT  = 1;
  localparam logic [15:0] WCOUNT_RST   = 16'h0000;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_RX,
    ST_ACK,
    ST_TX,
    ST_TXACK
  } isnbm_state_e;

  typedef enum logic [1:0] {
    K_DEV,
    K_WORD,
    K_DATA
  } isnbm_kind_e;

endpackage : isnbm_pkg

// ### verification/isnbm_checker.sv
// Checker for isnbm_top: APB answer timing and serial pin driving.
// Assumes a bind from the bench; it sees the top ports only.
`timescale 1ns/1ps
`default_nettype none

module isnbm_checker (
  input wire logic        sys_clk_i,
  input wire logic        resetn_i,
  input wire logic        link_clk_i,
  input wire logic [11:0] paddr_i,
  input wire logic        psel_i,
  input wire logic        penable_i,
  input wire logic        pwrite_i,
  input wire logic [31:0] prdata_o,
  input wire logic        pready_o,
  input wire logic        pslverr_o,
  input wire logic        scl_i,
  input wire logic        sda_o,
  input wire logic        sda_oe_o
);
  wire logic setup  = psel_i && !penable_i;
  wire logic mapped = paddr_i inside {12'h000, 12'h004, 12'h008};

  // ************
  // Assertions
  // ************
  a_sda_low_only: assert property (
    @(posedge link_clk_i) disable iff (!resetn_i) sda_o == 1'b0)
    else $error("serial data driven high");
  a_oe_on_low: assert property (
    @(posedge link_clk_i) disable iff (!resetn_i)
    $changed(sda_oe_o) |-> !scl_i)
    else $error("serial output changed while clock high");
  // A stuck pull-down would hang every device on the wire.
  a_oe_released: assert property (
    @(posedge link_clk_i) disable iff (!resetn_i)
    sda_oe_o |-> ##[1:200] !sda_oe_o)
    else $error("serial data held low too long");
  a_apb_ready: assert property (
    @(posedge sys_clk_i) disable iff (!resetn_i) setup |=> pready_o)
    else $error("no ready after setup");
  a_ready_pulse: assert property (
    @(posedge sys_clk_i) disable iff (!resetn_i) pready_o |=> !pready_o)
    else $error("ready longer than one cycle");
  a_err_unmapped: assert property (
    @(posedge sys_clk_i) disable iff (!resetn_i)
    setup && !mapped |=> pslverr_o && prdata_o == 32'h0000_0000)
    else $error("unmapped access not refused");
  a_err_ro_write: assert property (
    @(posedge sys_clk_i) disable iff (!resetn_i)
    setup && pwrite_i && paddr_i != 12'h000 |=> pslverr_o)
    else $error("read-only write not refused");
  a_ok_mapped: assert property (
    @(posedge sys_clk_i) disable iff (!resetn_i)
    setup && mapped && !pwrite_i |=> !pslverr_o)
    else $error("mapped read refused");
  a_ctrl_rsvd: assert property (
    @(posedge sys_clk_i) disable iff (!resetn_i)
    setup && !pwrite_i && paddr_i == 12'h000 |=> prdata_o[31:1] == '0)
    else $error("control reserved bits set");

  c_read: cover property (@(posedge sys_clk_i) setup && !pwrite_i);
  c_err: cover property (@(posedge sys_clk_i) pready_o && pslverr_o);
  c_drive: cover property (@(posedge link_clk_i) $rose(sda_oe_o));
endmodule : isnbm_checker

`default_nettype wire

// ### verification/isnbm_i2c_mst.sv
// Behavioural two-wire bus master for the serial byte memory bench.
// Assumes the bench resolves the open-drain wire and feeds it back.
`timescale 1ns/1ps
`default_nettype none

module isnbm_i2c_mst (
  input  wire logic       link_clk_i,
  input  wire logic       sda_i,
  output var  logic       scl_o,
  output var  logic       sda_low_o,
  output var  logic       res_vld_o,
  output var  logic [8:0] res_o
);
  // Four link clocks high and five low, just under 1 MHz.
  localparam int HALF = 4;

  initial begin
    scl_o = 1'b1;
    sda_low_o = 1'b0;
    res_vld_o = 1'b0;
    res_o = '0;
  end

  task automatic hold(input int n);
    repeat (n) @(posedge link_clk_i);
  endtask : hold

  // The clock stands high between frames.
  task automatic start();
    hold(1);
    sda_low_o <= 1'b0;
    hold(HALF);
    scl_o <= 1'b1;
    hold(HALF);
    sda_low_o <= 1'b1;
    hold(HALF);
    scl_o <= 1'b0;
  endtask : start

  task automatic stop();
    hold(1);
    sda_low_o <= 1'b1;
    hold(HALF);
    scl_o <= 1'b1;
    hold(HALF);
    sda_low_o <= 1'b0;
    hold(HALF);
  endtask : stop

  // Result is {slave ack, byte seen}, with the ack bit zero on reads; a cut-short byte gives none.
  task automatic xfer(input logic [7:0] b, input int n,
                      input logic rd, input logic mack);
    logic [8:0] v;
    logic [8:0] s;
    int         lo;
    v = {rd ? 8'hFF : b, rd ? !mack : 1'b1};
    lo = (n == 8) ? 0 : 9 - n;
    for (int i = 8; i >= lo; i--) begin
      hold(1);
      sda_low_o <= !v[i];
      hold(HALF);
      scl_o <= 1'b1;
      hold(HALF);
      s[i] = sda_i;
      scl_o <= 1'b0;
    end
    if (n == 8) begin
      res_o <= {rd ? 1'b0 : !s[0], s[8:1]};
      res_vld_o <= 1'b1;
      hold(1);
      res_vld_o <= 1'b0;
    end
  endtask : xfer
endmodule : isnbm_i2c_mst

`default_nettype wire

// ### verification/isnbm_top_tb.sv
// Bench for isnbm_top: APB register checks and serial transfers.
// Assumes the partner master isnbm_i2c_mst and the bound checker.
`timescale 1ns/1ps
`default_nettype none

module isnbm_top_tb;
  import isnbm_pkg::*;
  localparam logic [3:0] TYPE = 4'h9; // Arbitrary device type code.
  localparam logic [1:0] SEL  = 2'b10;
  logic        sys_clk  = 1'b0;
  logic        link_clk = 1'b0;
  logic        resetn   = 1'b0;
  logic [11:0] paddr    = '0;
  logic        psel     = 1'b0;
  logic        penable  = 1'b0;
  logic        pwrite   = 1'b0;
  logic [31:0] pwdata   = '0;
  logic        wp       = 1'b0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        scl;
  logic        sda_o;
  logic        sda_oe;
  logic        sda_low;
  logic        res_vld;
  logic [8:0]  res;
  logic [7:0]  mem [512];
  logic [7:0]  d;
  int          n_errors = 0;
  int          checked  = 0;
  int          seed     = 74329;
  logic [32:0] apb_q [$];
  logic [8:0]  ser_q [$];
  // Pull-up wire: low while either party pulls it.
  wire logic   sda = !(sda_oe || sda_low);

  always #20 sys_clk = !sys_clk;
  always #62.5 link_clk = !link_clk;

  isnbm_top #(.DEV_TYPE(TYPE)) u_dut (
    .sys_clk_i(sys_clk), .resetn_i(resetn), .link_clk_i(link_clk),
    .paddr_i(paddr), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .pwdata_i(pwdata), .pstrb_i(4'hF),
    .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
    .scl_i(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe_o(sda_oe),
    .wp_i(wp), .device_select_pins_i(SEL));
  isnbm_i2c_mst u_mst (.link_clk_i(link_clk), .sda_i(sda), .scl_o(scl),
    .sda_low_o(sda_low), .res_vld_o(res_vld), .res_o(res));

  task automatic end_of_test();
    $display("checked=%0d n_errors=%0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : end_of_test

  task automatic chk_apb(input logic [32:0] e, g);
    checked++;
    if (g !== e) begin
      n_errors++;
      $display("[FAIL] apb expected %h seen %h", e, g);
    end
  endtask : chk_apb

  task automatic chk_ser(input logic [8:0] e, g);
    checked++;
    if (g !== e) begin
      n_errors++;
      $display("[FAIL] serial expected %h seen %h", e, g);
    end
  endtask : chk_ser

  always @(posedge sys_clk) begin
    if (psel && penable && pready === 1'b1) begin
      chk_apb(apb_q.size() ? apb_q.pop_front() : 'x,
              {pslverr, pwrite ? 32'h0000_0000 : prdata});
    end
  end
  always @(posedge link_clk) begin
    if (res_vld === 1'b1) begin
      chk_ser(ser_q.size() ? ser_q.pop_front() : 'x, res);
    end
  end

  task automatic apb(input logic [11:0] a, input logic w,
                     input logic [31:0] wd, input logic [32:0] e);
    int k;
    apb_q.push_back(e);
    @(posedge sys_clk);
    psel <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= wd;
    @(posedge sys_clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge sys_clk);
      k++;
    end while (pready !== 1'b1 && k < 16);
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      n_errors++;
      end_of_test();
    end
  endtask : apb

  task automatic wb(input logic [7:0] b, input logic ack);
    ser_q.push_back({ack, b});
    u_mst.xfer(b, 8, 1'b0, 1'b0);
  endtask : wb
  task automatic rb(input logic [7:0] e, input logic mack);
    ser_q.push_back({1'b0, e});
    u_mst.xfer(8'hFF, 8, 1'b1, mack);
  endtask : rb
  function automatic logic [7:0] dev(input logic p, input logic r);
    return {TYPE, SEL, p, r};
  endfunction : dev
  task automatic wr_at(input logic p, input logic [7:0] w);
    u_mst.start();
    wb(dev(p, 1'b0), 1'b1);
    wb(w, 1'b1);
  endtask : wr_at
  task automatic rd_at(input logic p, input logic [7:0] w);
    wr_at(p, w);
    u_mst.start();
    wb(dev(p, 1'b1), 1'b1);
  endtask : rd_at

  // ************
  // Scenarios
  // ************
  initial begin
    repeat (10) @(posedge sys_clk);
    resetn <= 1'b1;
    apb(CTRL_OFF, 1'b0, '0, 33'h0_0000_0001);
    apb(WCOUNT_OFF, 1'b0, '0, 33'h0_0000_0000);
    apb(STATUS_OFF, 1'b0, '0, 33'h0_0000_0000);
    apb(12'h00C, 1'b0, '0, 33'h1_0000_0000);
    apb(STATUS_OFF, 1'b1, '1, 33'h1_0000_0000);
    u_mst.start();
    wb({4'h5, SEL, 2'b00}, 1'b0);
    u_mst.stop();
    u_mst.start();
    wb({TYPE, 2'b01, 2'b00}, 1'b0);
    u_mst.stop();
    wr_at(1'b1, 8'hFE);
    for (int i = 0; i < 3; i++) begin
      d = 8'($random(seed));
      mem[9'h1FE + 9'(i)] = d;
      wb(d, 1'b1);
    end
    u_mst.stop();
    rd_at(1'b1, 8'hFE);
    rb(mem[9'h1FE], 1'b1);
    rb(mem[9'h1FF], 1'b1);
    rb(mem[9'h000], 1'b0);
    u_mst.stop();
    apb(WCOUNT_OFF, 1'b0, '0, 33'h0_0000_0003);
    @(posedge sys_clk);
    wp <= 1'b1;
    // The level crosses two synchronisers before status can show it.
    repeat (20) @(posedge sys_clk);
    apb(STATUS_OFF, 1'b0, '0, 33'h0_0000_0002);
    wr_at(1'b1, 8'hFE);
    wb(~mem[9'h1FE], 1'b1);
    u_mst.stop();
    @(posedge sys_clk);
    wp <= 1'b0;
    u_mst.start();
    wb(dev(1'b1, 1'b1), 1'b1);
    rb(mem[9'h1FF], 1'b0);
    u_mst.stop();
    rd_at(1'b1, 8'hFE);
    rb(mem[9'h1FE], 1'b0);
    u_mst.stop();
    apb(WCOUNT_OFF, 1'b0, '0, 33'h0_0000_0003);
    wr_at(1'b0, 8'h00);
    u_mst.xfer(~mem[9'h000], 5, 1'b0, 1'b0);
    u_mst.stop();
    rd_at(1'b0, 8'h00);
    rb(mem[9'h000], 1'b0);
    u_mst.stop();
    apb(CTRL_OFF, 1'b1, '0, 33'h0_0000_0000);
    apb(CTRL_OFF, 1'b0, '0, 33'h0_0000_0000);
    u_mst.start();
    wb(dev(1'b0, 1'b1), 1'b0);
    u_mst.stop();
    apb(CTRL_OFF, 1'b1, 32'h0000_0001, 33'h0_0000_0000);
    apb(CTRL_OFF, 1'b0, '0, 33'h0_0000_0001);
    end_of_test();
  end

  initial begin
    repeat (60000) @(posedge sys_clk);
    n_errors++;
    end_of_test();
  end
endmodule : isnbm_top_tb

bind isnbm_top isnbm_checker u_chk (
  .sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .link_clk_i(link_clk_i),
  .paddr_i(paddr_i), .psel_i(psel_i), .penable_i(penable_i),
  .pwrite_i(pwrite_i), .prdata_o(prdata_o), .pready_o(pready_o),
  .pslverr_o(pslverr_o), .scl_i(scl_i), .sda_o(sda_o),
  .sda_oe_o(sda_oe_o));

`default_nettype wire
